// *** numbering_pkg.sv ***
// numbering counter package: command codes, register offsets, reset
// values and the structs and enums shared by the counter files.
// assumes a single 50 MHz clock domain and byte-wide command input.
package numbering_pkg;

  // ***********************************************************
  // command byte codes
  // ***********************************************************
  localparam logic [7:0] CMD_LEAD = 8'h1d;
  localparam logic [7:0] OP_PRINT = 8'h63;
  localparam logic [7:0] OP_CSET = 8'h43;
  localparam logic [7:0] SUB_FMT = 8'h30;
  localparam logic [7:0] SUB_RANGE = 8'h31;
  localparam logic [7:0] SUB_VALUE = 8'h32;
  localparam logic [2:0] NPAR_FMT = 3'h2;
  localparam logic [2:0] NPAR_RANGE = 3'h6;
  localparam logic [2:0] NPAR_VALUE = 3'h2;
  localparam logic [2:0] MAX_DIGITS = 3'h5;
  localparam logic [1:0] MAX_JUST = 2'h2;
  localparam logic [1:0] JUST_SPACE = 2'h0;
  localparam logic [1:0] JUST_ZERO = 2'h1;
  localparam logic [1:0] JUST_LEFT = 2'h2;

  // ***********************************************************
  // values after reset
  // ***********************************************************
  localparam logic [15:0] RST_START = 16'h0001;
  localparam logic [15:0] RST_END = 16'hffff;
  localparam logic [7:0] RST_STEP = 8'h01;
  localparam logic [7:0] RST_REPEAT = 8'h01;
  localparam logic [15:0] RST_VALUE = 16'h0001;
  localparam logic [2:0] RST_DIGITS = 3'h0;
  localparam logic [1:0] RST_JUST = 2'h0;

  // ***********************************************************
  // register byte offsets
  // ***********************************************************
  localparam logic [4:0] ADDR_CMD = 5'h00;
  localparam logic [4:0] ADDR_STATUS = 5'h04;
  localparam logic [4:0] ADDR_VALUE = 5'h08;
  localparam logic [4:0] ADDR_FORMAT = 5'h0c;
  localparam logic [4:0] ADDR_RANGE = 5'h10;
  localparam logic [4:0] ADDR_STEPREP = 5'h14;

  // ***********************************************************
  // characters and counts
  // ***********************************************************
  localparam logic [7:0] CH_SPACE = 8'h20;
  localparam logic [7:0] CH_ZERO = 8'h30;
  localparam logic [7:0] CH_NINE = 8'h39;
  localparam logic [4:0] BCD_CYCLES = 5'h10;

  typedef struct packed {
    logic [15:0] start_val;
    logic [15:0] end_val;
    logic [7:0] step_size;
    logic [7:0] repeat_count;
  } range_cfg_s;

  typedef struct packed {
    logic [2:0] digits;
    logic [1:0] just;
  } fmt_cfg_s;

  typedef struct packed {
    logic [4:0] address;
    logic read;
    logic write;
    logic [31:0] writedata;
    logic [3:0] byteenable;
  } avm_req_s;

  typedef enum logic [1:0] {
    CNT_HOLD = 2'b00,
    CNT_UP = 2'b01,
    CNT_DOWN = 2'b11
  } cnt_mode_e;

  typedef enum logic [1:0] {
    P_IDLE = 2'b00,
    P_CONV = 2'b01,
    P_EMIT = 2'b11,
    P_STEP = 2'b10
  } prt_state_e;

  typedef enum logic [1:0] {
    K_IDLE = 2'b00,
    K_LEAD = 2'b01,
    K_SUB = 2'b11,
    K_PARAM = 2'b10
  } cmd_state_e;

endpackage

// *** bin_to_bcd.sv ***
// sequential binary to five-digit decimal converter (shift and add 3).
// assumes start is a one-cycle pulse; the input is registered with it.
`timescale 1ns/10ps
`default_nettype none
module bin_to_bcd (
  // clock and reset
  input wire logic mclk_i,
  input wire logic rstn_i,
  // request
  input wire logic start_i,
  input wire logic [15:0] bin_i,
  // result
  output logic [19:0] bcd_o,
  output logic done_o
);
  import numbering_pkg::*;

  logic [19:0] bcd_ff;
  logic [15:0] sh_ff;
  logic [4:0] cnt_ff;
  logic busy_ff;
  logic done_ff;
  logic [19:0] adj;

  always_comb begin
    adj = bcd_ff;
    for (int k = 0; k < 5; k++) begin
      if (bcd_ff[k*4 +: 4] >= 4'h5) begin
        adj[k*4 +: 4] = bcd_ff[k*4 +: 4] + 4'h3;
      end
    end
  end

  always_ff @(posedge mclk_i) begin
    if (!rstn_i) begin
      bcd_ff <= 20'h00000;
      sh_ff <= 16'h0000;
      cnt_ff <= 5'h00;
      busy_ff <= 1'b0;
      done_ff <= 1'b0;
    end else if (start_i) begin
      bcd_ff <= 20'h00000;
      sh_ff <= bin_i;
      cnt_ff <= 5'h00;
      busy_ff <= 1'b1;
      done_ff <= 1'b0;
    end else if (busy_ff) begin
      bcd_ff <= {adj[18:0], sh_ff[15]};
      sh_ff <= {sh_ff[14:0], 1'b0};
      cnt_ff <= cnt_ff + 5'h01;
      busy_ff <= (cnt_ff != BCD_CYCLES - 5'h01);
      done_ff <= (cnt_ff == BCD_CYCLES - 5'h01);
    end else begin
      done_ff <= 1'b0;
    end
  end

  assign bcd_o = bcd_ff;
  assign done_o = done_ff;

endmodule
`default_nettype wire

// *** field_char.sv ***
// picks the character at one position of the formatted counter field
// and reports the field width; purely combinational.
// assumes the decimal digits are stable while the field is walked.
`timescale 1ns/10ps
`default_nettype none
module field_char (
  // inputs
  input wire logic [19:0] bcd_i,
  input wire numbering_pkg::fmt_cfg_s fmt_i,
  input wire logic [2:0] idx_i,
  // outputs
  output logic [7:0] char_o,
  output logic [2:0] width_o
);
  import numbering_pkg::*;

  logic [2:0] act;
  logic [2:0] nd;
  logic [2:0] pos;
  logic fill;

  always_comb begin
    act = 3'h1;
    for (int k = 1; k < 5; k++) begin
      if (bcd_i[k*4 +: 4] != 4'h0) begin
        act = 3'(k + 1);
      end
    end
    width_o = (fmt_i.digits == 3'h0) ? act : fmt_i.digits;
    // a wider value keeps only its low digits
    nd = (act < width_o) ? act : width_o;
    pos = 3'h0;
    fill = 1'b0;
    if (fmt_i.just == JUST_LEFT && fmt_i.digits != 3'h0) begin
      if (idx_i < nd) begin
        pos = nd - 3'h1 - idx_i;
      end else begin
        fill = 1'b1;
      end
    end else begin
      pos = width_o - 3'h1 - idx_i;
      fill = (pos >= nd);
    end
    if (!fill) begin
      char_o = CH_ZERO | {4'h0, bcd_i[pos*4 +: 4]};
    end else if (fmt_i.just == JUST_ZERO && fmt_i.digits != 3'h0) begin
      char_o = CH_ZERO;
    end else begin
      char_o = CH_SPACE;
    end
  end

endmodule
`default_nettype wire

// *** numbering_counter_unit.sv ***
// numbering counter: parses command bytes written over avalon-mm,
// keeps range, step, repeat and format, and streams the formatted
// counter value out as characters on each print command.
// assumes the avalon master holds each request until waitrequest falls.
`timescale 1ns/10ps
`default_nettype none
module numbering_counter_unit (
  // clock and reset
  input wire logic mclk_i,
  input wire logic rstn_i,
  // avalon-mm slave
  input wire numbering_pkg::avm_req_s avs_req_i,
  output logic [31:0] avs_readdata_o,
  output logic avs_waitrequest_o,
  // print buffer character stream
  output logic [7:0] pb_char_o,
  output logic pb_valid_o
);
  import numbering_pkg::*;

  // ***********************************************************
  // declarations
  // ***********************************************************
  range_cfg_s cfg_ff;
  fmt_cfg_s fmt_ff;
  logic [15:0] value_ff;
  logic [7:0] rep_ff;
  logic fmt_rej_ff;
  cmd_state_e kst_ff;
  logic [7:0] sub_ff;
  logic [7:0] par_ff [6];
  logic [2:0] pidx_ff;
  prt_state_e pst_ff;
  logic [2:0] cidx_ff;
  logic wait_ff;
  logic [31:0] rdata_ff;
  logic [7:0] pb_char_ff;
  logic pb_valid_ff;

  logic busy;
  logic byte_go;
  logic [7:0] wbyte;
  logic [7:0] cur [6];
  logic [2:0] need;
  logic last_par;
  logic fmt_apply;
  logic fmt_bad;
  logic range_apply;
  logic value_apply;
  logic print_go;
  cnt_mode_e mode;
  logic [15:0] lim_min;
  logic [15:0] lim_max;
  logic out_range;
  logic [15:0] print_val;
  logic rep_last;
  logic [16:0] up_sum;
  logic up_wrap;
  logic dn_wrap;
  logic [15:0] next_val;
  logic [19:0] bcd;
  logic conv_done;
  logic [7:0] fch;
  logic [2:0] fwidth;
  logic [31:0] rd_mux;

  // ***********************************************************
  // avalon-mm slave
  // ***********************************************************
  assign busy = (pst_ff != P_IDLE);
  assign wbyte = avs_req_i.writedata[7:0];
  assign byte_go = !wait_ff && avs_req_i.write && avs_req_i.byteenable[0]
                   && avs_req_i.address == ADDR_CMD;

  always_comb begin
    rd_mux = 32'h00000000;
    case (avs_req_i.address)
      ADDR_STATUS: rd_mux = {16'h0000, rep_ff, 4'h0, fmt_rej_ff, mode, busy};
      ADDR_VALUE: rd_mux = {16'h0000, value_ff};
      ADDR_FORMAT: rd_mux = {26'h0000000, fmt_ff.just, 1'b0, fmt_ff.digits};
      ADDR_RANGE: rd_mux = {cfg_ff.end_val, cfg_ff.start_val};
      ADDR_STEPREP: rd_mux = {16'h0000, cfg_ff.repeat_count, cfg_ff.step_size};
      default: rd_mux = 32'h00000000;
    endcase
  end

  // a command byte waits while a print is running, so the parser never
  // changes the settings under a field that is being emitted
  always_ff @(posedge mclk_i) begin
    if (!rstn_i) begin
      wait_ff <= 1'b1;
      rdata_ff <= 32'h00000000;
    end else begin
      wait_ff <= !((avs_req_i.read || avs_req_i.write) && wait_ff
                   && !(avs_req_i.write && busy));
      if (avs_req_i.read && wait_ff) begin
        rdata_ff <= rd_mux;
      end
    end
  end

  // ***********************************************************
  // command parser
  // ***********************************************************
  always_comb begin
    for (int i = 0; i < 6; i++) begin
      cur[i] = (byte_go && 3'(i) == pidx_ff) ? wbyte : par_ff[i];
    end
    case (sub_ff)
      SUB_FMT: need = NPAR_FMT;
      SUB_RANGE: need = NPAR_RANGE;
      default: need = NPAR_VALUE;
    endcase
    last_par = byte_go && kst_ff == K_PARAM && pidx_ff == need - 3'h1;
    fmt_apply = last_par && sub_ff == SUB_FMT;
    range_apply = last_par && sub_ff == SUB_RANGE;
    value_apply = last_par && sub_ff == SUB_VALUE;
    fmt_bad = cur[0] > {5'h00, MAX_DIGITS} || cur[1] > {6'h00, MAX_JUST};
    print_go = byte_go && kst_ff == K_LEAD && wbyte == OP_PRINT;
  end

  always_ff @(posedge mclk_i) begin
    if (!rstn_i) begin
      kst_ff <= K_IDLE;
      sub_ff <= 8'h00;
      pidx_ff <= 3'h0;
      for (int i = 0; i < 6; i++) begin
        par_ff[i] <= 8'h00;
      end
    end else if (byte_go) begin
      case (kst_ff)
        K_IDLE: begin
          if (wbyte == CMD_LEAD) begin
            kst_ff <= K_LEAD;
          end
        end
        K_LEAD: begin
          if (wbyte == OP_CSET) begin
            kst_ff <= K_SUB;
          end else if (wbyte != CMD_LEAD) begin
            kst_ff <= K_IDLE;
          end
        end
        K_SUB: begin
          pidx_ff <= 3'h0;
          sub_ff <= wbyte;
          if (wbyte == SUB_FMT || wbyte == SUB_RANGE || wbyte == SUB_VALUE) begin
            kst_ff <= K_PARAM;
          end else begin
            kst_ff <= K_IDLE;
          end
        end
        K_PARAM: begin
          par_ff[pidx_ff] <= wbyte;
          pidx_ff <= pidx_ff + 3'h1;
          if (last_par) begin
            kst_ff <= K_IDLE;
          end
        end
        default: kst_ff <= K_IDLE;
      endcase
    end
  end

  // ***********************************************************
  // format and range settings
  // ***********************************************************
  always_ff @(posedge mclk_i) begin
    if (!rstn_i) begin
      fmt_ff.digits <= RST_DIGITS;
      fmt_ff.just <= RST_JUST;
      fmt_rej_ff <= 1'b0;
    end else if (fmt_apply) begin
      fmt_rej_ff <= fmt_bad;
      if (!fmt_bad) begin
        fmt_ff.digits <= cur[0][2:0];
        fmt_ff.just <= cur[1][1:0];
      end
    end
  end

  always_ff @(posedge mclk_i) begin
    if (!rstn_i) begin
      cfg_ff.start_val <= RST_START;
      cfg_ff.end_val <= RST_END;
      cfg_ff.step_size <= RST_STEP;
      cfg_ff.repeat_count <= RST_REPEAT;
    end else if (range_apply) begin
      cfg_ff.start_val <= {cur[1], cur[0]};
      cfg_ff.end_val <= {cur[3], cur[2]};
      cfg_ff.step_size <= cur[4];
      cfg_ff.repeat_count <= cur[5];
    end
  end

  // ***********************************************************
  // counting mode and next value
  // ***********************************************************
  always_comb begin
    if (cfg_ff.step_size == 8'h00 || cfg_ff.repeat_count == 8'h00
        || cfg_ff.start_val == cfg_ff.end_val) begin
      mode = CNT_HOLD;
    end else if (cfg_ff.start_val < cfg_ff.end_val) begin
      mode = CNT_UP;
    end else begin
      mode = CNT_DOWN;
    end
    lim_min = (mode == CNT_UP) ? cfg_ff.start_val : cfg_ff.end_val;
    lim_max = (mode == CNT_UP) ? cfg_ff.end_val : cfg_ff.start_val;
    out_range = mode != CNT_HOLD && (value_ff < lim_min || value_ff > lim_max);
    if (out_range && mode == CNT_UP) begin
      print_val = lim_min;
    end else if (out_range) begin
      print_val = lim_max;
    end else begin
      print_val = value_ff;
    end
    rep_last = {1'b0, rep_ff} + 9'h001 >= {1'b0, cfg_ff.repeat_count};
    up_sum = {1'b0, value_ff} + {9'h000, cfg_ff.step_size};
    up_wrap = up_sum > {1'b0, lim_max};
    dn_wrap = {1'b0, value_ff} < {1'b0, lim_min} + {9'h000, cfg_ff.step_size};
    if (mode == CNT_UP) begin
      next_val = up_wrap ? lim_min : up_sum[15:0];
    end else begin
      next_val = dn_wrap ? lim_max : value_ff - {8'h00, cfg_ff.step_size};
    end
  end

  // value and repetitions never change under a print: command bytes
  // are held off by waitrequest until the print has stepped
  always_ff @(posedge mclk_i) begin
    if (!rstn_i) begin
      value_ff <= RST_VALUE;
      rep_ff <= 8'h00;
    end else if (value_apply) begin
      value_ff <= {cur[1], cur[0]};
      rep_ff <= 8'h00;
    end else if (range_apply) begin
      rep_ff <= 8'h00;
    end else if (print_go) begin
      value_ff <= print_val;
    end else if (pst_ff == P_STEP && mode != CNT_HOLD) begin
      if (rep_last) begin
        rep_ff <= 8'h00;
        value_ff <= next_val;
      end else begin
        rep_ff <= rep_ff + 8'h01;
      end
    end
  end

  // ***********************************************************
  // print sequence
  // ***********************************************************
  bin_to_bcd u_bcd (
    .mclk_i(mclk_i),
    .rstn_i(rstn_i),
    .start_i(print_go),
    .bin_i(print_val),
    .bcd_o(bcd),
    .done_o(conv_done)
  );

  field_char u_field (
    .bcd_i(bcd),
    .fmt_i(fmt_ff),
    .idx_i(cidx_ff),
    .char_o(fch),
    .width_o(fwidth)
  );

  always_ff @(posedge mclk_i) begin
    if (!rstn_i) begin
      pst_ff <= P_IDLE;
      cidx_ff <= 3'h0;
      pb_char_ff <= 8'h00;
      pb_valid_ff <= 1'b0;
    end else begin
      pb_valid_ff <= 1'b0;
      case (pst_ff)
        P_IDLE: begin
          if (print_go) begin
            pst_ff <= P_CONV;
          end
        end
        P_CONV: begin
          cidx_ff <= 3'h0;
          if (conv_done) begin
            pst_ff <= P_EMIT;
          end
        end
        P_EMIT: begin
          pb_char_ff <= fch;
          pb_valid_ff <= 1'b1;
          cidx_ff <= cidx_ff + 3'h1;
          if (cidx_ff == fwidth - 3'h1) begin
            pst_ff <= P_STEP;
          end
        end
        P_STEP: pst_ff <= P_IDLE;
        default: pst_ff <= P_IDLE;
      endcase
    end
  end

  assign avs_readdata_o = rdata_ff;
  assign avs_waitrequest_o = wait_ff;
  assign pb_char_o = pb_char_ff;
  assign pb_valid_o = pb_valid_ff;

  // ***********************************************************
  // assertions
  // ***********************************************************
  sequence s_print_start;
    pst_ff == P_IDLE && print_go;
  endsequence

  sequence s_adv;
    pst_ff == P_STEP && mode != CNT_HOLD && rep_last;
  endsequence

  property p_print_done;
    @(posedge mclk_i) disable iff (!rstn_i)
    s_print_start |=> pst_ff == P_CONV ##[17:30] pst_ff == P_STEP;
  endproperty
  a_print_done: assert property (p_print_done)
    else $error("print did not finish in time");

  property p_force_min;
    @(posedge mclk_i) disable iff (!rstn_i)
    s_print_start and (mode == CNT_UP && out_range) |=> value_ff == lim_min;
  endproperty
  a_force_min: assert property (p_force_min)
    else $error("up mode did not force minimum");

  property p_force_max;
    @(posedge mclk_i) disable iff (!rstn_i)
    s_print_start and (mode == CNT_DOWN && out_range) |=> value_ff == lim_max;
  endproperty
  a_force_max: assert property (p_force_max)
    else $error("down mode did not force maximum");

  property p_no_pad;
    @(posedge mclk_i) disable iff (!rstn_i)
    pst_ff == P_EMIT && fmt_ff.digits == 3'h0 |=> pb_char_o != CH_SPACE;
  endproperty
  a_no_pad: assert property (p_no_pad)
    else $error("padding seen with digit count zero");

  property p_width;
    @(posedge mclk_i) disable iff (!rstn_i)
    pst_ff == P_STEP && fmt_ff.digits != 3'h0
      |-> $past(cidx_ff) == fmt_ff.digits - 3'h1;
  endproperty
  a_width: assert property (p_width)
    else $error("field width differs from digit count");

  property p_zero_fill;
    @(posedge mclk_i) disable iff (!rstn_i)
    pst_ff == P_EMIT && fmt_ff.just == JUST_ZERO && fmt_ff.digits != 3'h0
      |=> pb_char_o >= CH_ZERO && pb_char_o <= CH_NINE;
  endproperty
  a_zero_fill: assert property (p_zero_fill)
    else $error("zero fill produced a non digit");

  property p_fmt_reject;
    @(posedge mclk_i) disable iff (!rstn_i)
    fmt_apply && fmt_bad |=> fmt_ff == $past(fmt_ff) && fmt_rej_ff;
  endproperty
  a_fmt_reject: assert property (p_fmt_reject)
    else $error("bad format command changed settings");

  property p_init_fmt;
    @(posedge mclk_i) disable iff (!rstn_i)
    $rose(rstn_i) |-> fmt_ff.digits == 3'h0;
  endproperty
  a_init_fmt: assert property (p_init_fmt)
    else $error("digit count not zero after reset");

  property p_range_load;
    @(posedge mclk_i) disable iff (!rstn_i)
    range_apply |=> cfg_ff.start_val == {$past(cur[1]), $past(cur[0])}
      && rep_ff == 8'h00;
  endproperty
  a_range_load: assert property (p_range_load)
    else $error("range command load wrong");

  property p_hold;
    @(posedge mclk_i) disable iff (!rstn_i)
    pst_ff == P_STEP && mode == CNT_HOLD |=> $stable(value_ff);
  endproperty
  a_hold: assert property (p_hold)
    else $error("held counter changed");

  property p_step_up;
    @(posedge mclk_i) disable iff (!rstn_i)
    s_adv and (mode == CNT_UP && !up_wrap)
      |=> value_ff == $past(up_sum[15:0]);
  endproperty
  a_step_up: assert property (p_step_up)
    else $error("up step wrong");

  property p_up_wrap;
    @(posedge mclk_i) disable iff (!rstn_i)
    s_adv and (mode == CNT_UP && up_wrap) |=> value_ff == lim_min;
  endproperty
  a_up_wrap: assert property (p_up_wrap)
    else $error("up wrap did not reload minimum");

  property p_dn_wrap;
    @(posedge mclk_i) disable iff (!rstn_i)
    s_adv and (mode == CNT_DOWN && dn_wrap) |=> value_ff == lim_max;
  endproperty
  a_dn_wrap: assert property (p_dn_wrap)
    else $error("down wrap did not reload maximum");

  property p_value_load;
    @(posedge mclk_i) disable iff (!rstn_i)
    value_apply |=> value_ff == {$past(cur[1]), $past(cur[0])}
      && rep_ff == 8'h00;
  endproperty
  a_value_load: assert property (p_value_load)
    else $error("value command load wrong");

endmodule
`default_nettype wire

// *** numbering_host.sv ***
// host model: avalon-mm master that sends command bytes, reads registers.
// assumes one clock and a slave that answers by dropping waitrequest.
`timescale 1ns/10ps
`default_nettype none
module numbering_host (
  // clock
  input wire logic mclk_i,
  // avalon-mm master
  output var numbering_pkg::avm_req_s avs_req_o,
  input wire logic [31:0] avs_readdata_i,
  input wire logic avs_waitrequest_i
);
  import numbering_pkg::*;
  // ***********************************************************
  // bus cycle
  // ***********************************************************
  initial avs_req_o = '0;
  // waitrequest and read data are taken at the rising edge, before the
  // slave's flops move; only the bench watchdog ends a stalled wait
  task automatic xfer(input logic [4:0] a, input logic r,
                      input logic [31:0] d, output logic [31:0] q);
    avs_req_o <= '{address: a, read: r, write: !r, writedata: d,
                   byteenable: 4'hf};
    do begin
      @(posedge mclk_i);
    end while (avs_waitrequest_i !== 1'b0);
    q = avs_readdata_i;
    avs_req_o <= '0;
    @(posedge mclk_i);
  endtask
endmodule
`default_nettype wire

// *** test_numbering_counter_unit.sv ***
// testbench: drives command bytes through the host model, checks chars.
// assumes the host model and the counter share one 50 MHz clock.
`timescale 1ns/10ps
`default_nettype none
module test_numbering_counter_unit;
  import numbering_pkg::*;
  typedef logic [7:0] bytes_t[$];
  logic mclk_i = 1'b0;
  logic rstn_i = 1'b0;
  avm_req_s avs_req;
  logic [31:0] rdata;
  logic avs_wait;
  logic [7:0] pb_char;
  logic pb_valid;
  logic [39:0] shr = '0;
  int nch = 0;
  int n_mismatch = 0;
  int samples_checked = 0;
  logic [39:0] jexp[3] = '{40'h202037, 40'h303037, 40'h372020};
  logic [15:0] vexp[6] = '{16'd5, 16'd0, 16'd0, 16'd50, 16'd50, 16'd45};
  logic [39:0] dexp[6] = '{40'h35, 40'h35, 40'h30, 40'h30, 40'h3530,
                           40'h3530};
  // ***********************************************************
  // clock, instances, print capture
  // ***********************************************************
  always #10 mclk_i = ~mclk_i;
  numbering_counter_unit dut_u (.mclk_i(mclk_i), .rstn_i(rstn_i),
    .avs_req_i(avs_req), .avs_readdata_o(rdata),
    .avs_waitrequest_o(avs_wait), .pb_char_o(pb_char),
    .pb_valid_o(pb_valid));
  numbering_host host_u (.mclk_i(mclk_i), .avs_req_o(avs_req),
    .avs_readdata_i(rdata), .avs_waitrequest_i(avs_wait));
  always @(posedge mclk_i) begin
    if (pb_valid === 1'b1) begin
      shr <= {shr[31:0], pb_char};
      nch <= nch + 1;
    end
  end
  // ***********************************************************
  // tasks
  // ***********************************************************
  task automatic check(input logic [39:0] seen, input logic [39:0] exp);
    samples_checked++;
    if (seen !== exp) begin
      n_mismatch++;
      $display("wrong value at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic end_sim;
    if (n_mismatch == 0 && samples_checked > 0)
      $display("SIMULATION PASSED");
    else
      $display("SIMULATION FAILED");
    $finish;
  endtask
  task automatic rd(input logic [4:0] a, input logic [31:0] e);
    logic [31:0] q;
    host_u.xfer(a, 1'b1, 32'h0, q);
    check({8'h0, q}, {8'h0, e});
  endtask
  task automatic cmds(input bytes_t b);
    logic [31:0] q;
    foreach (b[i]) host_u.xfer(ADDR_CMD, 1'b0, {24'h0, b[i]}, q);
  endtask
  task automatic fmt(input logic [7:0] d, input logic [7:0] j);
    cmds('{CMD_LEAD, OP_CSET, SUB_FMT, d, j});
  endtask
  task automatic setv(input logic [15:0] v);
    cmds('{CMD_LEAD, OP_CSET, SUB_VALUE, v[7:0], v[15:8]});
  endtask
  task automatic rng(input logic [15:0] s, input logic [15:0] e,
                     input logic [7:0] st, input logic [7:0] rp);
    cmds('{CMD_LEAD, OP_CSET, SUB_RANGE, s[7:0], s[15:8], e[7:0],
           e[15:8], st, rp});
  endtask
  // w of zero skips the character compare
  task automatic prt(input logic [39:0] e, input int w);
    int n0;
    int k;
    logic [31:0] q;
    n0 = nch;
    k = 0;
    cmds('{CMD_LEAD, OP_PRINT});
    do begin
      host_u.xfer(ADDR_STATUS, 1'b1, 32'h0, q);
      k++;
    end while (q[0] !== 1'b0 && k < 60);
    if (w > 0) begin
      check(shr & ((40'h1 << (8 * w)) - 40'h1), e);
      check(40'(nch - n0), 40'(w));
    end
  endtask
  // ***********************************************************
  // tests
  // ***********************************************************
  initial begin
    #(20 * 20000);
    n_mismatch++;
    end_sim;
  end
  initial begin
    repeat (20) @(posedge mclk_i);
    rstn_i <= 1'b1;
    @(posedge mclk_i);
    rd(ADDR_FORMAT, 32'h0);
    rd(ADDR_RANGE, 32'hffff0001);
    rd(ADDR_STEPREP, 32'h0101);
    rd(ADDR_VALUE, 32'h1);
    rd(5'h1c, 32'h0);
    prt(40'h31, 1);
    rd(ADDR_VALUE, 32'h2);
    for (int j = 0; j < 3; j++) begin
      fmt(8'h3, 8'(j));
      setv(16'd7);
      prt(jexp[j], 3);
    end
    fmt(8'h6, 8'h0);
    fmt(8'h1, 8'h3);
    rd(ADDR_FORMAT, 32'h23);
    rd(ADDR_STATUS, 32'h0a);
    fmt(8'h2, 8'h0);
    setv(16'd12345);
    prt(40'h3435, 2);
    fmt(8'h0, 8'h1);
    setv(16'd12345);
    prt(40'h3132333435, 5);
    rng(16'h0103, 16'h0201, 8'h5, 8'h1);
    rd(ADDR_RANGE, 32'h02010103);
    setv(16'd513);
    prt(40'h353133, 3);
    rd(ADDR_VALUE, 32'd259);
    setv(16'd600);
    prt(40'h323539, 3);
    rd(ADDR_VALUE, 32'd264);
    rng(16'd50, 16'd0, 8'h5, 8'h2);
    setv(16'd5);
    for (int i = 0; i < 6; i++) begin
      prt(dexp[i], (i < 4) ? 1 : 2);
      rd(ADDR_VALUE, {16'h0, vexp[i]});
    end
    prt(40'h3435, 2);
    rd(ADDR_STATUS, 32'h106);
    rng(16'd50, 16'd0, 8'h5, 8'h2);
    prt(40'h3435, 2);
    rd(ADDR_VALUE, 32'd45);
    setv(16'd60);
    prt(40'h3530, 2);
    rng(16'd5, 16'd9, 8'h0, 8'h1);
    setv(16'd7);
    prt(40'h37, 1);
    rd(ADDR_VALUE, 32'd7);
    rng(16'd9, 16'd9, 8'h1, 8'h1);
    prt(40'h37, 1);
    rd(ADDR_VALUE, 32'd7);
    end_sim;
  end
endmodule
`default_nettype wire
